// ===== logic/lifecycle_defs.vh
`ifndef LIFECYCLE_DEFS_VH
`define LIFECYCLE_DEFS_VH

// Framing bytes
`define START_HEADER 8'h01
`define DATA_FRAME_START 8'h81
`define END_BYTE 8'h03
`define UNUSED_CODE 8'hff
`define RESP_LEN 8'h0a
`define OK_SUM 8'h8d
`define RESP_BYTES 4'd15
`define ERR_BIT 8'h80

// Command codes
`define CMD_TRANSIT 8'h71
`define CMD_TRANSIT_ERR 8'hf1
`define CMD_STATE_REQ 8'h2c
`define CMD_PROT_REQ 8'h2d
`define CMD_AUTH_REQ 8'h2e
`define CMD_AUTH 8'h30
`define CMD_KEY_VERIFY 8'h29
`define CMD_UKEY_VERIFY 8'h2a
`define CMD_BOUND_REQ 8'h4f
`define CMD_PARAM_REQ 8'h52
`define CMD_INQUIRY 8'h00
`define CMD_SIGNATURE 8'h3a
`define CMD_AREA_INFO 8'h3b
`define CMD_BAUD 8'h34
`define CMD_CRC 8'h18
`define CMD_CERT_CHECK 8'h76
`define TRANSIT_LEN 16'h0003

// Lifecycle state codes
`define LC_OEM 8'h04
`define LC_LOCKED_BOOT 8'h06
`define LC_RETURN_REQ 8'h07
`define LC_RETURN_ACK 8'h08
`define LC_RETURNED 8'h09

// Status codes
`define STS_OK 8'h00
`define STS_PACKET 8'hc1
`define STS_CHECKSUM 8'hc2
`define STS_PARAM 8'hd0
`define STS_ACCEPT 8'hd5
`define STS_PROTECT 8'hda

// Register offsets
`define REG_CTRL 12'h000
`define REG_STATE 12'h004
`define REG_INT_STATUS 12'h008
`define REG_INT_MASK 12'h00c

// Field positions
`define CTRL_LOCK_EN 0
`define INT_OK 0
`define INT_ERR 1
`define INT_HALT 2
`define INT_FWD 3
`define INT_BITS 4

// Reset values
`define CTRL_RESET 1'b0
`define MASK_RESET 4'h0

`endif

// ===== logic/byte_sum.v
`timescale 1ns/1ps
// Running 8-bit sum of a byte stream
module byte_sum (
	// Clock and reset
	input wire pclk,
	input wire presetn,
	// Control and data
	input wire clear,
	input wire add,
	input wire [7:0] data,
	output reg [7:0] sum_r
);
	// Clear wins so a new frame never inherits old bytes
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sum_r <= 8'h00;
		end else if (clear) begin
			sum_r <= 8'h00;
		end else if (add) begin
			sum_r <= sum_r + data;
		end
	end
endmodule // byte_sum

// ===== logic/lifecycle_transit_command_handler.v
`timescale 1ns/1ps
`include "lifecycle_defs.vh"

// Notes on behaviour
// - Transit frame: 01,00,03,71,src,dst,sum,03
// - Source codes: 04 original, 08 acknowledged
// - Destination codes: 06 locked, 09 returned
// - Success: code 71, status 00, FF details
// - Success frame 81, length 0A, 8D, 03
// - Failure: code F1, length 0A, computed sum
// - Transit needs no authentication first
// - Locked or returned: go silent until reset
// - Check each command against current state
// - Original state admits every command
// - Return-requested admits only query-type commands
// - Locked strap at reset: software reset, never accept
// - Drop bytes until start-of-header arrives
// - Source mismatch: parameter error, no change
// - Locked transition needs enable, else protection
// - Inadmissible command reports status D5
module lifecycle_transit_command_handler #(
	parameter MAX_BODY = 16'h0400
) (
	// APB
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	// Received byte stream
	input wire rx_valid,
	input wire [7:0] rx_data,
	output reg rx_ready,
	// Response byte stream
	output reg tx_valid,
	output reg [7:0] tx_data,
	input wire tx_ready,
	// Admitted commands for other handlers
	output reg fwd_valid,
	output reg [7:0] fwd_code,
	// Lifecycle
	input wire [7:0] lifecycle_strap,
	output reg [7:0] lifecycle_state,
	output reg sw_reset_req,
	output reg halted,
	// Interrupt
	output reg irq
);
	localparam ST_INIT = 4'd0;
	localparam ST_HUNT = 4'd1;
	localparam ST_LENH = 4'd2;
	localparam ST_LENL = 4'd3;
	localparam ST_BODY = 4'd4;
	localparam ST_SUM = 4'd5;
	localparam ST_END = 4'd6;
	localparam ST_EVAL = 4'd7;
	localparam ST_SEND = 4'd8;
	localparam ST_HALT = 4'd9;

	reg [3:0] state_r;
	reg [3:0] state_nxt;
	reg [15:0] len_r;
	reg [15:0] cnt_r;
	reg [7:0] code_r;
	reg [7:0] src_r;
	reg [7:0] dst_r;
	reg sum_ok_r;
	reg end_ok_r;
	reg [7:0] resp_code_r;
	reg [7:0] resp_sts_r;
	reg [3:0] tx_idx_r;
	reg halt_after_r;
	reg lock_en_r;
	reg [`INT_BITS-1:0] int_status_r;
	reg [`INT_BITS-1:0] int_mask_r;
	reg [`INT_BITS-1:0] int_set;
	reg [7:0] tx_byte;
	reg [7:0] eval_sts;
	reg eval_fwd;
	wire [7:0] rx_sum;
	wire [7:0] tx_sum;
	wire rx_take;
	wire tx_take;
	wire body_last;
	wire [7:0] tx_sum_final;
	wire apb_access;

	assign rx_take = rx_valid && rx_ready;
	assign tx_take = tx_valid && tx_ready;
	assign body_last = (cnt_r + 16'h0001) == len_r;
	assign apb_access = psel && penable && pready;

	// Admission by state
	function admitted;
		input [7:0] lc;
		input [7:0] code;
		begin
			if (lc == `LC_RETURN_REQ) begin
				case (code)
				`CMD_STATE_REQ, `CMD_PROT_REQ, `CMD_AUTH_REQ, `CMD_AUTH,
				`CMD_KEY_VERIFY, `CMD_UKEY_VERIFY, `CMD_BOUND_REQ,
				`CMD_PARAM_REQ, `CMD_INQUIRY, `CMD_SIGNATURE, `CMD_AREA_INFO,
				`CMD_BAUD, `CMD_CRC, `CMD_CERT_CHECK: admitted = 1'b1;
				default: admitted = 1'b0;
				endcase
			end else begin
				admitted = 1'b1;
			end
		end
	endfunction

	// Checksum over length bytes through payload and the sum byte
	byte_sum u_rx_sum (
		.pclk(pclk),
		.presetn(presetn),
		.clear(state_r == ST_HUNT),
		.add(rx_take && (state_r != ST_HUNT) && (state_r != ST_END)),
		.data(rx_data),
		.sum_r(rx_sum)
	);

	// Outgoing sum over length through last payload byte
	byte_sum u_tx_sum (
		.pclk(pclk),
		.presetn(presetn),
		.clear(state_r == ST_EVAL),
		.add(tx_take && (tx_idx_r != 4'd0) && (tx_idx_r < 4'd13)),
		.data(tx_data),
		.sum_r(tx_sum)
	);
	assign tx_sum_final = 8'h00 - tx_sum;

	// Response bytes by position
	always @* begin
		case (tx_idx_r)
		4'd0: tx_byte = `DATA_FRAME_START;
		4'd1: tx_byte = 8'h00;
		4'd2: tx_byte = `RESP_LEN;
		4'd3: tx_byte = resp_code_r;
		4'd4: tx_byte = resp_sts_r;
		4'd13: tx_byte = tx_sum_final;
		4'd14: tx_byte = `END_BYTE;
		default: tx_byte = `UNUSED_CODE;
		endcase
	end

	// Checks in descending priority
	always @* begin
		eval_fwd = 1'b0;
		if (!end_ok_r) begin
			eval_sts = `STS_PACKET;
		end else if (!sum_ok_r) begin
			eval_sts = `STS_CHECKSUM;
		end else if (len_r == 16'h0000 || len_r > MAX_BODY) begin
			eval_sts = `STS_PACKET;
		end else if (code_r == `CMD_TRANSIT && len_r != `TRANSIT_LEN) begin
			eval_sts = `STS_PACKET;
		end else if (!admitted(lifecycle_state, code_r)) begin
			eval_sts = `STS_ACCEPT;
		end else if (code_r != `CMD_TRANSIT) begin
			eval_sts = `STS_OK;
			eval_fwd = 1'b1;
		end else if (src_r != lifecycle_state) begin
			eval_sts = `STS_PARAM;
		end else if (!((src_r == `LC_OEM && dst_r == `LC_LOCKED_BOOT) ||
				(src_r == `LC_RETURN_ACK && dst_r == `LC_RETURNED))) begin
			eval_sts = `STS_PARAM;
		end else if (dst_r == `LC_LOCKED_BOOT && !lock_en_r) begin
			eval_sts = `STS_PROTECT;
		end else begin
			eval_sts = `STS_OK;
		end
	end

	// Next state
	always @* begin
		state_nxt = state_r;
		case (state_r)
		ST_INIT: begin
			if (lifecycle_strap == `LC_LOCKED_BOOT) begin
				state_nxt = ST_HALT;
			end else begin
				state_nxt = ST_HUNT;
			end
		end
		ST_HUNT: begin
			if (rx_take && rx_data == `START_HEADER) begin
				state_nxt = ST_LENH;
			end
		end
		ST_LENH: begin
			if (rx_take) begin
				state_nxt = ST_LENL;
			end
		end
		ST_LENL: begin
			if (rx_take) begin
				state_nxt = ({len_r[15:8], rx_data} == 16'h0000) ? ST_SUM : ST_BODY;
			end
		end
		ST_BODY: begin
			if (rx_take && body_last) begin
				state_nxt = ST_SUM;
			end
		end
		ST_SUM: begin
			if (rx_take) begin
				state_nxt = ST_END;
			end
		end
		ST_END: begin
			if (rx_take) begin
				state_nxt = ST_EVAL;
			end
		end
		ST_EVAL: state_nxt = eval_fwd ? ST_HUNT : ST_SEND;
		ST_SEND: begin
			if (tx_take && tx_idx_r == `RESP_BYTES - 4'd1) begin
				state_nxt = halt_after_r ? ST_HALT : ST_HUNT;
			end
		end
		ST_HALT: state_nxt = ST_HALT;
		default: state_nxt = ST_HUNT;
		endcase
	end

	// Frame assembly and response control
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r <= ST_INIT;
			len_r <= 16'h0000;
			cnt_r <= 16'h0000;
			code_r <= 8'h00;
			src_r <= 8'h00;
			dst_r <= 8'h00;
			sum_ok_r <= 1'b0;
			end_ok_r <= 1'b0;
			resp_code_r <= 8'h00;
			resp_sts_r <= 8'h00;
			tx_idx_r <= 4'd0;
			halt_after_r <= 1'b0;
			lifecycle_state <= 8'h00;
			sw_reset_req <= 1'b0;
			halted <= 1'b0;
			rx_ready <= 1'b0;
			tx_valid <= 1'b0;
			tx_data <= 8'h00;
			fwd_valid <= 1'b0;
			fwd_code <= 8'h00;
		end else begin
			state_r <= state_nxt;
			fwd_valid <= 1'b0;
			// Ready only in receiving states; held low while answering
			rx_ready <= (state_nxt >= ST_HUNT) && (state_nxt <= ST_END);
			halted <= (state_nxt == ST_HALT);
			if (state_r == ST_INIT) begin
				lifecycle_state <= lifecycle_strap; // Caught after release
				if (lifecycle_strap == `LC_LOCKED_BOOT) begin
					sw_reset_req <= 1'b1;
				end
			end
			if (state_r == ST_HUNT) begin
				cnt_r <= 16'h0000;
			end
			if (rx_take) begin
				case (state_r)
				ST_LENH: len_r[15:8] <= rx_data;
				ST_LENL: len_r[7:0] <= rx_data;
				ST_BODY: begin
					cnt_r <= cnt_r + 16'h0001;
					if (cnt_r == 16'h0000) begin
						code_r <= rx_data;
					end
					if (cnt_r == 16'h0001) begin
						src_r <= rx_data;
					end
					if (cnt_r == 16'h0002) begin
						dst_r <= rx_data;
					end
				end
				ST_SUM: sum_ok_r <= (rx_sum + rx_data) == 8'h00;
				ST_END: end_ok_r <= (rx_data == `END_BYTE);
				default: cnt_r <= cnt_r;
				endcase
			end
			if (state_r == ST_EVAL) begin
				tx_idx_r <= 4'd0;
				resp_sts_r <= eval_sts;
				if (eval_fwd) begin
					fwd_valid <= 1'b1;
					fwd_code <= code_r;
				end
				if (eval_sts == `STS_OK) begin
					resp_code_r <= code_r;
				end else begin
					resp_code_r <= code_r | `ERR_BIT;
				end
				// Only a successful transit changes the state
				if (!eval_fwd && eval_sts == `STS_OK) begin
					lifecycle_state <= dst_r;
					halt_after_r <= (dst_r == `LC_LOCKED_BOOT) ||
						(dst_r == `LC_RETURNED);
				end else begin
					halt_after_r <= 1'b0;
				end
			end
			// Byte pump toward the transport
			if (state_r == ST_SEND) begin
				if (!tx_valid) begin
					tx_valid <= 1'b1;
					tx_data <= tx_byte;
				end else if (tx_ready) begin
					tx_valid <= 1'b0;
					tx_idx_r <= tx_idx_r + 4'd1;
				end
			end else begin
				tx_valid <= 1'b0;
			end
		end
	end

	// Interrupt events
	always @* begin
		int_set = {`INT_BITS{1'b0}};
		int_set[`INT_OK] = (state_r == ST_EVAL) && !eval_fwd && (eval_sts == `STS_OK);
		int_set[`INT_ERR] = (state_r == ST_EVAL) && (eval_sts != `STS_OK);
		int_set[`INT_HALT] = (state_r != ST_HALT) && (state_nxt == ST_HALT);
		int_set[`INT_FWD] = (state_r == ST_EVAL) && eval_fwd;
	end

	// APB slave, no wait states; unmapped reads zero with an error
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
			lock_en_r <= `CTRL_RESET;
			int_status_r <= {`INT_BITS{1'b0}};
			int_mask_r <= `MASK_RESET;
			irq <= 1'b0;
		end else begin
			pready <= psel && !penable && !pready;
			if (psel && !penable && !pready) begin
				pslverr <= 1'b0;
				prdata <= 32'h00000000;
				case (paddr)
				`REG_CTRL: prdata[`CTRL_LOCK_EN] <= lock_en_r;
				`REG_STATE: prdata <= {22'h0, sw_reset_req, halted, lifecycle_state};
				`REG_INT_STATUS: prdata[`INT_BITS-1:0] <= int_status_r;
				`REG_INT_MASK: prdata[`INT_BITS-1:0] <= int_mask_r;
				default: pslverr <= 1'b1;
				endcase
			end
			if (apb_access && pwrite && paddr == `REG_CTRL) begin
				lock_en_r <= pwdata[`CTRL_LOCK_EN];
			end
			if (apb_access && pwrite && paddr == `REG_INT_MASK) begin
				int_mask_r <= pwdata[`INT_BITS-1:0];
			end
			// Set beats a same-cycle write-one clear
			if (apb_access && pwrite && paddr == `REG_INT_STATUS) begin
				int_status_r <= (int_status_r & ~pwdata[`INT_BITS-1:0]) | int_set;
			end else begin
				int_status_r <= int_status_r | int_set;
			end
			irq <= |(int_status_r & int_mask_r);
		end
	end
endmodule // lifecycle_transit_command_handler

// ===== bench/lc_chk_sva.sv
`timescale 1ns/1ps
// Port checks of the command handler
module lc_chk (
	// Clock, reset
	input wire pclk,
	input wire presetn,
	// Bus
	input wire psel,
	input wire penable,
	input wire pready,
	// Streams
	input wire rx_ready,
	input wire tx_valid,
	input wire [7:0] tx_data,
	input wire tx_ready,
	input wire fwd_valid,
	input wire [7:0] fwd_code,
	// Lifecycle
	input wire [7:0] lifecycle_state,
	input wire sw_reset_req,
	input wire halted
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Bus answers one cycle after setup
	property p_ans; psel && !penable |=> pready; endproperty
	a_ans: assert property (p_ans) else $error("no bus answer");
	// Reply byte held until taken
	property p_hold; tx_valid && !tx_ready |=> tx_valid && $stable(tx_data); endproperty
	a_hold: assert property (p_hold) else $error("reply byte dropped");
	// No intake while replying
	property p_half; tx_valid |-> !rx_ready; endproperty
	a_half: assert property (p_half) else $error("intake during reply");
	property p_fwd; fwd_valid |-> fwd_code != 8'h71 ##1 !fwd_valid; endproperty
	a_fwd: assert property (p_fwd) else $error("bad forward");
	property p_quiet; halted |-> !rx_ready && !fwd_valid ##1 halted; endproperty
	a_quiet: assert property (p_quiet) else $error("halted but active");
	property p_rise; $rose(halted) |-> lifecycle_state inside {8'h06, 8'h09}; endproperty
	a_rise: assert property (p_rise) else $error("halt in wrong state");
	property p_lock; sw_reset_req |-> lifecycle_state == 8'h06 && halted; endproperty
	a_lock: assert property (p_lock) else $error("bad soft reset");
	// First edge after release only captures the strap
	property p_dest;
		lifecycle_state != $past(lifecycle_state) && $past(lifecycle_state) != 8'h00
			|-> lifecycle_state inside {8'h06, 8'h09};
	endproperty
	a_dest: assert property (p_dest) else $error("bad state change");
	c_tx: cover property (tx_valid && !tx_ready);
	c_fwd: cover property (fwd_valid);
	c_halt: cover property ($rose(halted));
endmodule // lc_chk

bind lifecycle_transit_command_handler lc_chk u_chk (.pclk, .presetn, .psel, .penable,
	.pready, .rx_ready, .tx_valid, .tx_data, .tx_ready, .fwd_valid, .fwd_code,
	.lifecycle_state, .sw_reset_req, .halted);

// ===== bench/host_tool.sv
`timescale 1ns/1ps
// Host programming tool on the serial side
module host_tool (
	// Clock
	input wire pclk,
	// Command stream
	output logic rx_valid,
	output logic [7:0] rx_data,
	input wire rx_ready,
	// Reply stream
	input wire tx_valid,
	input wire [7:0] tx_data,
	output logic tx_ready
);
	logic [7:0] r[0:15];
	int rn = 0;
	bit slow = 0;
	initial begin
		rx_valid = 1'b0;
		rx_data = 8'h5a;
		tx_ready = 1'b0;
	end
	// Collect reply bytes; slow sink stalls every other cycle
	always @(posedge pclk) begin
		tx_ready <= slow ? ~tx_ready : 1'b1;
		if (tx_valid && tx_ready && rn < 16) begin
			r[rn] <= tx_data;
			rn <= rn + 1;
		end
	end
	// Valid stays up between bytes of one frame
	task automatic put(input logic [7:0] b);
		rx_valid <= 1'b1;
		rx_data <= b;
		do @(posedge pclk); while (!rx_ready);
	endtask
	// Whole frame; x skews the sum, y is the end byte
	task automatic send(input logic [7:0] c, a, b, input int n, input logic [7:0] x, y);
		logic [7:0] s;
		s = n[7:0] + c + (n == 3 ? a + b : 8'h00);
		put(8'h01);
		put(8'h00);
		put(n[7:0]);
		put(c);
		if (n == 3) begin
			put(a);
			put(b);
		end
		put(8'h00 - s + x);
		put(y);
		rx_valid <= 1'b0;
		rx_data <= ~y; // Released line shows no stale byte
	endtask
endmodule // host_tool

// ===== bench/lifecycle_transit_command_handler_tb.sv
`timescale 1ns/1ps
// Self-checking bench
module lifecycle_transit_command_handler_tb;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, irq;
	logic rx_valid, rx_ready, tx_valid, tx_ready, fwd_valid, sw_reset_req, halted;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic [7:0] rx_data, tx_data, fwd_code, lifecycle_strap, lifecycle_state;
	int n_fail = 0, check_count = 0, cyc = 0;

	// Design and host
	lifecycle_transit_command_handler dut (.pclk, .presetn, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr, .rx_valid, .rx_data, .rx_ready,
		.tx_valid, .tx_data, .tx_ready, .fwd_valid, .fwd_code, .lifecycle_strap,
		.lifecycle_state, .sw_reset_req, .halted, .irq);
	host_tool h (.pclk, .rx_valid, .rx_data, .rx_ready, .tx_valid, .tx_data, .tx_ready);

	initial begin
		pclk = 0;
		forever #5 pclk = ~pclk;
	end
	// Hang guard
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_fail++;
			report_and_stop();
		end
	end

	task automatic chk(input logic [32:0] g, e);
		check_count++;
		if (g !== e) begin
			n_fail++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	// One bus transfer; extra edge keeps psel from toggling twice
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (!pready);
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rc(input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk({err, q}, {1'b0, e});
	endtask
	task automatic rst(input logic [7:0] s);
		presetn <= 1'b0;
		lifecycle_strap <= s;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		repeat (2) @(posedge pclk);
	endtask
	// Send a frame and compare the 15-byte reply
	task automatic txn(input logic [7:0] c, a, b, input int n, input logic [7:0] x, y, r, s);
		logic [119:0] e;
		logic [7:0] su;
		int i;
		h.rn = 0;
		h.send(c, a, b, n, x, y);
		su = 8'hfe - r - s;
		e = {8'h81, 8'h00, 8'h0a, r, s, {8{8'hff}}, su, 8'h03};
		for (i = 0; i < 300 && h.rn < 15; i++) @(posedge pclk);
		chk(h.rn, 15);
		for (i = 0; i < 15; i++) chk(h.r[i], e[119 - 8 * i -: 8]);
	endtask
	task automatic fwd(input logic [7:0] c);
		int i;
		i = 0;
		h.send(c, 8'h00, 8'h00, 1, 8'h00, 8'h03);
		do begin
			@(posedge pclk);
			i++;
		end while (fwd_valid !== 1'b1 && i < 20);
		chk({fwd_valid, fwd_code}, {1'b1, c});
	endtask
	task report_and_stop;
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask

	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		rst(8'h04);
		rc(12'h000, 32'h0);
		rc(12'h004, 32'h4);
		apb(1'b0, 12'h010, 32'h0);
		chk({err, q}, 33'h100000000);
		wr(12'h00c, 32'h2);
		h.put(8'h55);
		fwd(8'h00);
		fwd(8'h15);
		$display("test forward done");
		txn(8'h71, 8'h04, 8'h06, 3, 8'h01, 8'h03, 8'hf1, 8'hc2);
		txn(8'h71, 8'h04, 8'h06, 3, 8'h00, 8'h55, 8'hf1, 8'hc1);
		txn(8'h71, 8'h04, 8'h06, 1, 8'h00, 8'h03, 8'hf1, 8'hc1);
		txn(8'h71, 8'h08, 8'h06, 3, 8'h00, 8'h03, 8'hf1, 8'hd0);
		txn(8'h71, 8'h04, 8'h09, 3, 8'h00, 8'h03, 8'hf1, 8'hd0);
		txn(8'h71, 8'h04, 8'h06, 3, 8'h00, 8'h03, 8'hf1, 8'hda);
		chk(irq, 1'b1);
		rc(12'h008, 32'ha);
		wr(12'h008, 32'hf);
		rc(12'h008, 32'h0);
		chk(irq, 1'b0);
		$display("test errors done");
		wr(12'h000, 32'h1);
		rc(12'h000, 32'h1);
		h.slow = 1;
		txn(8'h71, 8'h04, 8'h06, 3, 8'h00, 8'h03, 8'h71, 8'h00);
		repeat (4) @(posedge pclk);
		rc(12'h004, 32'h106);
		rc(12'h008, 32'h5);
		chk(rx_ready, 1'b0);
		rst(8'h07);
		txn(8'h71, 8'h07, 8'h09, 3, 8'h00, 8'h03, 8'hf1, 8'hd5);
		txn(8'h15, 8'h00, 8'h00, 1, 8'h00, 8'h03, 8'h95, 8'hd5);
		fwd(8'h2c);
		rst(8'h08);
		txn(8'h71, 8'h08, 8'h09, 3, 8'h00, 8'h03, 8'h71, 8'h00);
		rc(12'h004, 32'h109);
		rst(8'h06);
		chk({sw_reset_req, halted, rx_ready}, 3'b110);
		$display("test states done");
		report_and_stop();
	end
endmodule // lifecycle_transit_command_handler_tb
